// *** cfg_loader_defines.svh ***
// Constants for the strap and stored-configuration loader.
// Included by the loader and its checksum engine; holds definitions only.
`ifndef CFG_LOADER_DEFINES_SVH
`define CFG_LOADER_DEFINES_SVH

// ------------------------------------------------------------
// APB register byte offsets
// ------------------------------------------------------------
`define REG_CMD 12'h000
`define REG_STATUS 12'h004
`define REG_ADDR 12'h008
`define REG_VOUT0 12'h00C
`define REG_VOUT1 12'h010
`define REG_RATE 12'h014
`define REG_PHASE 12'h018
`define REG_LIMSEL 12'h01C
`define REG_LIMDATA 12'h020
`define REG_GCFG 12'h024

// ------------------------------------------------------------
// Commands, status bits, stored-word layout
// ------------------------------------------------------------
`define CMD_RELOAD 8'h01
`define CMD_SOFTRST 8'h02
`define CMD_STORE 8'h03
`define ST_CMLB 0
`define ST_CMLW 1
`define ST_NACK 6
`define RATE_SYNC_BIT 8
`define NVM_GCFG 3'h0
`define NVM_ADDR 3'h1
`define NVM_VOUT0 3'h2
`define NVM_VOUT1 3'h3
`define NVM_RATE 3'h4
`define NVM_PHASE 3'h5
`define GCFG_IGNORE_BIT 6
`define GCFG_CLKSLAVE_BIT 4
`define OPEN_ALOW 0
`define OPEN_AHIGH 1
`define OPEN_V0 2
`define OPEN_V1 3
`define OPEN_RATE 4
`define OPEN_PHASE 5

// ------------------------------------------------------------
// Addresses, voltages, limits, temperatures, checksum
// ------------------------------------------------------------
`define ADDR_GLOBAL0 7'h5A
`define ADDR_GLOBAL1 7'h5B
`define ADDR_RECOVER 7'h7C
`define RST_BUS_ADDR 7'h40
`define RATE_GND_CODE 4'h0
`define VOUT_BASE 16'h0100
`define VOUT_STEP 16'h0020
`define LIM_COUNT 4'hE
`define PCT_DIV 27'h000_03E8
`define PCT_OVF 11'h44C
`define PCT_OVW 11'h433
`define PCT_MAX 11'h433
`define PCT_MUP 11'h41A
`define PCT_MDN 11'h3B6
`define PCT_UVW 11'h3A7
`define PCT_UVF 11'h3A2
`define TEMP_LOCK 8'h82
`define TEMP_UNLOCK 8'h7D
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h1021

`endif

// *** cfg_loader_pkg.sv ***
// Types shared by the configuration loader files.
// Assumes nothing of its surroundings.
package cfg_loader_pkg;

	typedef enum {LD_IDLE, LD_ADDR, LD_DATA, LD_CHECK, LD_APPLY} load_state_t;
	typedef logic [15:0] word_t;

endpackage

// *** crc_if.sv ***
// Carrier between the loader and its checksum engine.
// Assumes one clock domain shared by both ends.
interface crc_if;
	logic clear;
	logic en;
	logic [15:0] data;
	logic [15:0] crc;
	modport engine (input clear, input en, input data, output crc);
	modport user (output clear, output en, output data, input crc);
endinterface

// *** crc_engine.sv ***
// Word-wide checksum engine used while the stored image is read.
// Assumes clear and en are never high together.
`include "cfg_loader_defines.svh"

module crc_engine
	import cfg_loader_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	crc_if.engine crcBus
);

	word_t crc_r;

	// ------------------------------------------------------------
	// Step over one 16-bit word, most significant bit first
	// ------------------------------------------------------------
	function automatic word_t step(input word_t c, input word_t d);
		word_t x;
		x = c;
		for (int b = 15; b >= 0; b--) begin
			if (x[15] ^ d[b]) begin
				x = {x[14:0], 1'b0} ^ `CRC_POLY;
			end else begin
				x = {x[14:0], 1'b0};
			end
		end
		return x;
	endfunction

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			crc_r <= `CRC_INIT;
		end else if (crcBus.clear) begin
			crc_r <= `CRC_INIT;
		end else if (crcBus.en) begin
			crc_r <= step(crc_r, crcBus.data);
		end
	end

	assign crcBus.crc = crc_r;

endmodule

// *** strap_config_loader.sv ***
// Strap and stored-configuration loader with APB register access.
// Assumes straps and temperature are synchronous to ref_clk and the memory
// returns the word one clock after nvmAddr changes.
//
// Local design decisions: the placing of the registers and the APB slave port.
`include "cfg_loader_defines.svh"

module strap_config_loader
	import cfg_loader_pkg::*;
#(
	parameter int NVM_WORDS = 8,
	parameter int NVM_AW = 3
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] addrLowStrap,
	input wire logic [2:0] addrHighStrap,
	input wire logic [4:0] out0LevelStrap,
	input wire logic [4:0] out1LevelStrap,
	input wire logic [3:0] rateStrap,
	input wire logic [2:0] phaseStrap,
	input wire logic [5:0] strapOpen,
	input wire logic [7:0] dieTemp,
	output logic [NVM_AW-1:0] nvmAddr,
	input wire logic [15:0] nvmData,
	output logic storeReq,
	input wire logic [6:0] hostAddr,
	input wire logic hostAddrValid,
	output logic addrAck,
	output logic [6:0] busAddr,
	output logic [15:0] vout0,
	output logic [15:0] vout1,
	output logic [3:0] rateSel,
	output logic [2:0] phaseSel,
	output logic syncEn,
	input wire logic alertIn,
	output logic alertOut,
	output logic alertOeN,
	input wire logic [1:0] runIn,
	output logic [1:0] runOut,
	output logic [1:0] runOeN
);

	load_state_t state_r;
	word_t image_r [NVM_WORDS];
	word_t lim_r [14];
	logic [NVM_AW-1:0] idx_r;
	logic startPend_r, crcErr_r, tempHot_r, cmlByte_r, cmlWord_r, nack_r;
	logic [3:0] snapLow_r, snapRate_r, limSel_r;
	logic [2:0] snapHigh_r, snapPhase_r;
	logic [4:0] snapV0_r, snapV1_r;
	logic [5:0] snapOpen_r;
	logic [7:0] lastCmd_r;
	logic acc, wrNow, cmdWr, idle, isReload, isStore, badCode, startLoad;
	logic storeOk, refused, crcBad, cmlSet, gIgn, lastIdx;
	logic [6:0] applyAddr;
	word_t applyV0, applyV1;
	logic [3:0] applyRate;
	logic [2:0] applyPhase;
	logic applySync, badAddr;
	logic [31:0] rdVal;

	crc_if crcBus ();

	crc_engine crcUnit (
		.ref_clk(ref_clk),
		.rst(rst),
		.crcBus(crcBus)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic word_t pct(input word_t v, input logic [10:0] k);
		logic [26:0] p;
		p = 27'(v) * 27'(k);
		return 16'(p / `PCT_DIV);
	endfunction

	function automatic logic [10:0] limPct(input int i);
		case (i)
			0: return `PCT_OVF;
			1: return `PCT_OVW;
			2: return `PCT_MAX;
			3: return `PCT_MUP;
			4: return `PCT_MDN;
			5: return `PCT_UVW;
			default: return `PCT_UVF;
		endcase
	endfunction

	function automatic word_t strapVolt(input logic [4:0] code);
		return 16'(`VOUT_BASE + 16'(code) * `VOUT_STEP);
	endfunction

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	assign acc = psel & penable;
	assign wrNow = acc & pready & pwrite;
	assign cmdWr = wrNow && (paddr == `REG_CMD);
	assign idle = (state_r == LD_IDLE);
	assign isReload = (pwdata[7:0] == `CMD_RELOAD) || (pwdata[7:0] == `CMD_SOFTRST);
	assign isStore = (pwdata[7:0] == `CMD_STORE);
	assign badCode = cmdWr & ~isReload & ~isStore;
	// Reload and soft reset stay allowed while hot; store does not.
	assign startLoad = idle & (startPend_r | (cmdWr & isReload));
	assign storeOk = cmdWr & isStore & idle & ~tempHot_r;
	assign refused = cmdWr & ~badCode & ~(isReload & idle) & ~storeOk;
	assign lastIdx = (32'(idx_r) == NVM_WORDS - 1);
	assign crcBad = (state_r == LD_CHECK) && (crcBus.crc != image_r[NVM_WORDS-1]);
	assign cmlSet = crcBad | badCode | (cmdWr & isStore & tempHot_r);

	// ------------------------------------------------------------
	// Load sequencer and checksum feed
	// ------------------------------------------------------------
	assign crcBus.clear = startLoad;
	assign crcBus.en = (state_r == LD_DATA) && !lastIdx;
	assign crcBus.data = nvmData;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= LD_IDLE;
			idx_r <= '0;
			nvmAddr <= '0;
			startPend_r <= 1'b1;
		end else begin
			case (state_r)
				LD_IDLE: begin
					if (startLoad) begin
						startPend_r <= 1'b0;
						idx_r <= '0;
						nvmAddr <= '0;
						state_r <= LD_ADDR;
					end
				end
				LD_ADDR: begin
					state_r <= LD_DATA;
				end
				LD_DATA: begin
					if (lastIdx) begin
						state_r <= LD_CHECK;
					end else begin
						idx_r <= NVM_AW'(idx_r + 1'b1);
						nvmAddr <= NVM_AW'(idx_r + 1'b1);
						state_r <= LD_ADDR;
					end
				end
				LD_CHECK: begin
					state_r <= LD_APPLY;
				end
				default: begin
					state_r <= LD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (state_r == LD_DATA) begin
			image_r[idx_r] <= nvmData;
		end
	end

	// ------------------------------------------------------------
	// Strap snapshot
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			snapLow_r <= '0;
			snapHigh_r <= '0;
			snapV0_r <= '0;
			snapV1_r <= '0;
			snapRate_r <= '0;
			snapPhase_r <= '0;
			snapOpen_r <= '1;
		end else if (startLoad) begin
			snapLow_r <= addrLowStrap;
			snapHigh_r <= addrHighStrap;
			snapV0_r <= out0LevelStrap;
			snapV1_r <= out1LevelStrap;
			snapRate_r <= rateStrap;
			snapPhase_r <= phaseStrap;
			snapOpen_r <= strapOpen;
		end
	end

	// ------------------------------------------------------------
	// Value selection between straps and stored words
	// ------------------------------------------------------------
	always_comb begin
		gIgn = image_r[`NVM_GCFG][`GCFG_IGNORE_BIT];
		applyAddr[3:0] = snapOpen_r[`OPEN_ALOW] ? image_r[`NVM_ADDR][3:0] : snapLow_r;
		applyAddr[6:4] = snapOpen_r[`OPEN_AHIGH] ? image_r[`NVM_ADDR][6:4] : snapHigh_r;
		applyV0 = image_r[`NVM_VOUT0];
		if (!snapOpen_r[`OPEN_V0] && !gIgn) begin
			applyV0 = strapVolt(snapV0_r);
		end
		applyV1 = image_r[`NVM_VOUT1];
		if (!snapOpen_r[`OPEN_V1] && !gIgn) begin
			applyV1 = strapVolt(snapV1_r);
		end
		applyRate = image_r[`NVM_RATE][3:0];
		applySync = !image_r[`NVM_GCFG][`GCFG_CLKSLAVE_BIT];
		if (!snapOpen_r[`OPEN_RATE] && !gIgn) begin
			applyRate = snapRate_r;
			applySync = (snapRate_r != `RATE_GND_CODE);
		end
		applyPhase = image_r[`NVM_PHASE][2:0];
		if (!snapOpen_r[`OPEN_PHASE] && !gIgn) begin
			applyPhase = snapPhase_r;
		end
	end

	// ------------------------------------------------------------
	// Live configuration, bus writes win over a load
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busAddr <= `RST_BUS_ADDR;
			vout0 <= '0;
			vout1 <= '0;
			rateSel <= '0;
			phaseSel <= '0;
			syncEn <= 1'b0;
		end else begin
			if (state_r == LD_APPLY) begin
				busAddr <= applyAddr;
				vout0 <= applyV0;
				vout1 <= applyV1;
				rateSel <= applyRate;
				phaseSel <= applyPhase;
				syncEn <= applySync;
			end
			if (wrNow) begin
				if (paddr == `REG_ADDR) begin
					busAddr <= pwdata[6:0];
				end else if (paddr == `REG_VOUT0) begin
					vout0 <= pwdata[15:0];
				end else if (paddr == `REG_VOUT1) begin
					vout1 <= pwdata[15:0];
				end else if (paddr == `REG_RATE) begin
					rateSel <= pwdata[3:0];
					syncEn <= pwdata[`RATE_SYNC_BIT];
				end else if (paddr == `REG_PHASE) begin
					phaseSel <= pwdata[2:0];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			limSel_r <= '0;
			for (int j = 0; j < 14; j++) begin
				lim_r[j] <= '0;
			end
		end else begin
			if (state_r == LD_APPLY) begin
				for (int i = 0; i < 7; i++) begin
					lim_r[i] <= pct(applyV0, limPct(i));
					lim_r[i + 7] <= pct(applyV1, limPct(i));
				end
			end
			if (wrNow && paddr == `REG_LIMSEL) begin
				limSel_r <= pwdata[3:0];
			end
			if (wrNow && paddr == `REG_LIMDATA && limSel_r < `LIM_COUNT) begin
				lim_r[limSel_r] <= pwdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Flags, temperature lockout, pins
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			crcErr_r <= 1'b0;
			tempHot_r <= 1'b0;
			cmlByte_r <= 1'b0;
			cmlWord_r <= 1'b0;
			nack_r <= 1'b0;
			lastCmd_r <= '0;
			storeReq <= 1'b0;
		end else begin
			if (state_r == LD_CHECK) begin
				crcErr_r <= crcBad;
			end
			if (dieTemp > `TEMP_LOCK) begin
				tempHot_r <= 1'b1;
			end else if (dieTemp < `TEMP_UNLOCK) begin
				tempHot_r <= 1'b0;
			end
			cmlByte_r <= cmlSet | (cmlByte_r & ~(wrNow && paddr == `REG_STATUS
				&& pwdata[`ST_CMLB]));
			cmlWord_r <= cmlSet | (cmlWord_r & ~(wrNow && paddr == `REG_STATUS
				&& pwdata[`ST_CMLW]));
			nack_r <= refused | (nack_r & ~(wrNow && paddr == `REG_STATUS
				&& pwdata[`ST_NACK]));
			if (cmdWr) begin
				lastCmd_r <= pwdata[7:0];
			end
			storeReq <= storeOk;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			alertOut <= 1'b0;
			alertOeN <= 1'b1;
			runOut <= 2'b00;
			runOeN <= 2'b11;
			addrAck <= 1'b0;
		end else begin
			alertOut <= 1'b0;
			runOut <= 2'b00;
			alertOeN <= ~crcErr_r;
			runOeN <= {2{~crcErr_r}};
			addrAck <= hostAddrValid && (hostAddr == `ADDR_GLOBAL0
				|| hostAddr == `ADDR_GLOBAL1
				|| hostAddr == (crcErr_r ? `ADDR_RECOVER : busAddr));
		end
	end

	// ------------------------------------------------------------
	// APB slave: one wait state, then the access completes
	// ------------------------------------------------------------
	always_comb begin
		rdVal = '0;
		badAddr = 1'b0;
		if (paddr == `REG_CMD) begin
			rdVal = {24'h00_0000, lastCmd_r};
		end else if (paddr == `REG_STATUS) begin
			rdVal = {22'h00_0000, alertIn, runIn, nack_r, !idle, crcErr_r, tempHot_r,
				crcErr_r, cmlWord_r, cmlByte_r};
		end else if (paddr == `REG_ADDR) begin
			rdVal = {25'h000_0000, busAddr};
		end else if (paddr == `REG_VOUT0) begin
			rdVal = {16'h0000, vout0};
		end else if (paddr == `REG_VOUT1) begin
			rdVal = {16'h0000, vout1};
		end else if (paddr == `REG_RATE) begin
			rdVal = {23'h00_0000, syncEn, 4'h0, rateSel};
		end else if (paddr == `REG_PHASE) begin
			rdVal = {29'h0000_0000, phaseSel};
		end else if (paddr == `REG_LIMSEL) begin
			rdVal = {28'h000_0000, limSel_r};
		end else if (paddr == `REG_LIMDATA) begin
			rdVal = (limSel_r < `LIM_COUNT) ? {16'h0000, lim_r[limSel_r]} : '0;
		end else if (paddr == `REG_GCFG) begin
			rdVal = {16'h0000, image_r[`NVM_GCFG]};
		end else begin
			badAddr = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= acc & ~pready;
			pslverr <= acc & ~pready & badAddr;
			if (acc & ~pready & ~pwrite) begin
				prdata <= rdVal;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence loadStart;
		state_r == LD_IDLE && startLoad;
	endsequence

	sequence reachCheck;
		##[1:40] state_r == LD_CHECK;
	endsequence

	snap_hold_a: assert property ($changed(snapRate_r) |-> $past(startLoad))
		else $error("rate strap snapshot changed without a load");
	full_check_a: assert property (loadStart |-> reachCheck)
		else $error("load did not reach checksum compare");
	both_open_a: assert property (state_r == LD_APPLY && &snapOpen_r[1:0] && !wrNow
		|=> busAddr == $past(image_r[`NVM_ADDR][6:0]))
		else $error("open address straps did not use stored address");
	addr_write_a: assert property (wrNow && paddr == `REG_ADDR
		|=> busAddr == $past(pwdata[6:0]))
		else $error("bus write did not override address");
	global_ack_a: assert property (hostAddrValid && hostAddr == `ADDR_GLOBAL1 |=> addrAck)
		else $error("global address not acknowledged");
	crc_fail_a: assert property (crcBad |=> crcErr_r && cmlByte_r && cmlWord_r
		##1 runOeN == 2'b00 && !alertOeN)
		else $error("checksum failure did not flag and pull pins low");
	recover_only_a: assert property (crcErr_r && hostAddrValid && hostAddr == busAddr
		&& busAddr != `ADDR_RECOVER && busAddr != `ADDR_GLOBAL0
		&& busAddr != `ADDR_GLOBAL1 |=> !addrAck)
		else $error("configured address answered after checksum failure");
	hot_lock_a: assert property (dieTemp > `TEMP_LOCK |=> tempHot_r)
		else $error("lockout not set when hot");
	cool_hold_a: assert property (tempHot_r && dieTemp >= `TEMP_UNLOCK |=> tempHot_r)
		else $error("lockout released above unlock level");
	store_refuse_a: assert property (cmdWr && isStore && tempHot_r
		|=> !storeReq && cmlByte_r && nack_r)
		else $error("store accepted while locked");
	limit_derive_a: assert property (state_r == LD_APPLY && !snapOpen_r[`OPEN_V0] && !gIgn
		|=> lim_r[0] == pct(strapVolt($past(snapV0_r)), `PCT_OVF))
		else $error("overvoltage limit not derived from strap");
	ignore_rate_a: assert property (state_r == LD_APPLY && gIgn && !wrNow
		|=> rateSel == $past(image_r[`NVM_RATE][3:0]))
		else $error("rate strap used while ignored");

endmodule

// *** nvm_model.sv ***
// Stored-configuration memory model for the loader bench.
// Assumes one word read per clock; the bench fills the array directly.
module nvm_model #(
	parameter int AW = 3
) (
	input wire logic ref_clk,
	input wire logic [AW-1:0] nvmAddr,
	output logic [15:0] nvmData
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:(1<<AW)-1];

	// The addressed word appears one clock after the address changes.
	always @(posedge ref_clk)
		nvmData <= mem[nvmAddr];
endmodule

// *** test_strap_config_loader.sv ***
// Self-checking bench for the strap and stored-configuration loader.
// Assumes the memory model answers one clock after the address changes.
`include "cfg_loader_defines.svh"
module test_strap_config_loader
	import cfg_loader_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q, r;
	logic pready, pslverr, storeReq, addrAck, syncEn, alertOut, alertOeN, lastErr;
	logic [3:0] addrLowStrap = '0, rateStrap = '0, rateSel;
	logic [2:0] addrHighStrap = '0, phaseStrap = '0, phaseSel, nvmAddr;
	logic [4:0] out0LevelStrap = '0, out1LevelStrap = '0;
	logic [5:0] strapOpen = '0;
	logic [7:0] dieTemp = 8'h19;
	logic [15:0] nvmData, vout0, vout1, eV0, eV1;
	logic [6:0] hostAddr = '0, busAddr, eAddr;
	logic hostAddrValid = 1'b0, eSync;
	logic [1:0] runOut, runOeN, runIn;
	logic [3:0] eRate;
	logic [2:0] ePhase;
	wire logic alertIn = (~alertOeN & alertOut) | alertOeN;
	int seed = 62, errors = 0, nChecks = 0, cycles = 0, nStore = 0;

	assign runIn = (~runOeN & runOut) | runOeN;
	always #10 ref_clk = ~ref_clk;

	nvm_model #(.AW(3)) nvm (.ref_clk(ref_clk), .nvmAddr(nvmAddr), .nvmData(nvmData));
	strap_config_loader #(.NVM_WORDS(8), .NVM_AW(3)) DUT (.ref_clk(ref_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .addrLowStrap(addrLowStrap),
		.addrHighStrap(addrHighStrap), .out0LevelStrap(out0LevelStrap),
		.out1LevelStrap(out1LevelStrap), .rateStrap(rateStrap), .phaseStrap(phaseStrap),
		.strapOpen(strapOpen), .dieTemp(dieTemp), .nvmAddr(nvmAddr), .nvmData(nvmData),
		.storeReq(storeReq), .hostAddr(hostAddr), .hostAddrValid(hostAddrValid),
		.addrAck(addrAck), .busAddr(busAddr), .vout0(vout0), .vout1(vout1),
		.rateSel(rateSel), .phaseSel(phaseSel), .syncEn(syncEn), .alertIn(alertIn),
		.alertOut(alertOut), .alertOeN(alertOeN), .runIn(runIn), .runOut(runOut),
		.runOeN(runOeN));

	task automatic complete_run();
		$display("checks %0d mismatches %0d", nChecks, errors);
		if (errors == 0 && nChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// A run that hangs counts as a mismatch.
	always @(posedge ref_clk) begin
		cycles++;
		if (storeReq === 1'b1)
			nStore++;
		if (cycles == 20000) begin
			errors++;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		nChecks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic waitIdle();
		do apb(1'b0, `REG_STATUS, '0); while (q[5] !== 1'b0);
	endtask

	function automatic logic [15:0] crcOf();
		logic [15:0] c;
		c = 16'hFFFF;
		for (int w = 0; w < 7; w++)
			for (int b = 15; b >= 0; b--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ nvm.mem[w][b]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction

	function automatic logic [15:0] lvl(input logic o, input logic [4:0] c, input logic [15:0] s);
		return o ? s : `VOUT_BASE + {11'h000, c} * `VOUT_STEP;
	endfunction

	task automatic load(input logic [7:0] cmd);
		logic [5:0] op;
		op = strapOpen | (nvm.mem[0][6] ? 6'h3C : 6'h00);
		eAddr = {op[1] ? nvm.mem[1][6:4] : addrHighStrap, op[0] ? nvm.mem[1][3:0] : addrLowStrap};
		eV0 = lvl(op[2], out0LevelStrap, nvm.mem[2]);
		eV1 = lvl(op[3], out1LevelStrap, nvm.mem[3]);
		eRate = op[4] ? nvm.mem[4][3:0] : rateStrap;
		ePhase = op[5] ? nvm.mem[5][2:0] : phaseStrap;
		eSync = op[4] ? ~nvm.mem[0][4] : (rateStrap != `RATE_GND_CODE);
		if (cmd != 8'h00)
			apb(1'b1, `REG_CMD, {24'h00_0000, cmd});
		waitIdle();
	endtask

	task automatic checkOut();
		chk("busAddr", eAddr, busAddr);
		chk("vout0", eV0, vout0);
		chk("vout1", eV1, vout1);
		chk("rateSel", eRate, rateSel);
		chk("phaseSel", ePhase, phaseSel);
		chk("syncEn", eSync, syncEn);
		apb(1'b1, `REG_LIMSEL, 32'h0000_0000);
		apb(1'b0, `REG_LIMDATA, 32'h0000_0000);
		chk("limit0", ({16'h0000, eV0} * 32'h0000_044C) / 32'h0000_03E8, q);
		apb(1'b1, `REG_LIMSEL, 32'h0000_000D);
		apb(1'b0, `REG_LIMDATA, 32'h0000_0000);
		chk("limit13", ({16'h0000, eV1} * 32'h0000_03A2) / 32'h0000_03E8, q);
	endtask

	task automatic ack(input logic [6:0] a, input logic e);
		hostAddr <= a;
		hostAddrValid <= 1'b1;
		@(posedge ref_clk);
		@(posedge ref_clk);
		chk("addrAck", {31'h0, e}, {31'h0, addrAck});
	endtask

	task automatic store(input logic [7:0] t, input logic e);
		dieTemp <= t;
		apb(1'b1, `REG_STATUS, 32'h0000_0043);
		apb(1'b1, `REG_CMD, {24'h00_0000, `CMD_STORE});
		apb(1'b0, `REG_STATUS, '0);
		chk("nack", {31'h0, e}, {31'h0, q[6]});
	endtask

	initial begin
		for (int i = 0; i < 7; i++)
			nvm.mem[i] = 16'($random(seed));
		nvm.mem[0][6] = 1'b0;
		nvm.mem[1][6:4] = 3'h1;
		nvm.mem[2][15] = 1'b0;
		nvm.mem[3][15] = 1'b0;
		nvm.mem[7] = crcOf();
		strapOpen = 6'h3F;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		load(8'h00);
		checkOut();
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			addrLowStrap <= r[3:0];
			addrHighStrap <= r[6:4];
			out0LevelStrap <= r[11:7];
			out1LevelStrap <= r[16:12];
			rateStrap <= (i == 2) ? 4'h0 : r[20:17];
			phaseStrap <= r[23:21];
			strapOpen <= (i == 0) ? 6'h01 : r[29:24];
			nvm.mem[0][6] = (i == 4);
			nvm.mem[7] = crcOf();
			@(posedge ref_clk);
			load((i % 2 == 0) ? `CMD_RELOAD : `CMD_SOFTRST);
			checkOut();
			strapOpen <= ~strapOpen;
			out0LevelStrap <= ~out0LevelStrap;
			repeat (25) @(posedge ref_clk);
			checkOut();
			$display("strap load %0d done", i);
		end
		apb(1'b1, `REG_ADDR, 32'h0000_0033);
		chk("busAddr", 32'h0000_0033, {25'h0, busAddr});
		apb(1'b1, `REG_VOUT0, 32'h0000_1234);
		chk("vout0", 32'h0000_1234, {16'h0, vout0});
		apb(1'b0, 12'h040, '0);
		chk("pslverr", 32'h0000_0001, {31'h0, lastErr});
		apb(1'b1, `REG_STATUS, 32'h0000_0043);
		apb(1'b1, `REG_CMD, 32'h0000_00A5);
		apb(1'b0, `REG_STATUS, '0);
		chk("badCmd", 32'h0000_0003, {30'h0, q[1:0]});
		apb(1'b0, `REG_CMD, '0);
		chk("lastCmd", 32'h0000_00A5, q);
		apb(1'b1, `REG_RATE, 32'h0000_0107);
		chk("rateOverride", 32'h0000_0107, {23'h0, syncEn, 4'h0, rateSel});
		ack(`ADDR_GLOBAL0, 1'b1);
		ack(`ADDR_GLOBAL1, 1'b1);
		ack(7'h33, 1'b1);
		ack(7'h34, 1'b0);
		$display("override and address test done");
		strapOpen <= 6'h00;
		addrHighStrap <= 3'h1;
		nvm.mem[0][6] = 1'b0;
		nvm.mem[7] = crcOf() ^ 16'h0001;
		@(posedge ref_clk);
		load(`CMD_RELOAD);
		chk("status", 32'h0000_0017, {27'h0, q[4:0]});
		chk("alertOeN", 32'h0000_0000, {31'h0, alertOeN});
		chk("runOeN", 32'h0000_0000, {30'h0, runOeN});
		chk("pinDrive", 32'h0000_0000, {29'h0, alertOut, runOut});
		apb(1'b0, `REG_STATUS, '0);
		chk("pinsLow", 32'h0000_0000, {29'h0, q[9:7]});
		ack(`ADDR_RECOVER, 1'b1);
		ack(eAddr, 1'b0);
		ack(`ADDR_GLOBAL1, 1'b1);
		nvm.mem[7] = crcOf();
		load(`CMD_RELOAD);
		chk("crcErr", 32'h0000_0000, {31'h0, q[2]});
		chk("alertOeN", 32'h0000_0001, {31'h0, alertOeN});
		chk("runOeN", 32'h0000_0003, {30'h0, runOeN});
		ack(eAddr, 1'b1);
		ack(`ADDR_RECOVER, 1'b0);
		$display("checksum test done");
		store(8'h83, 1'b1);
		chk("lockCml", 32'h0000_000B, {28'h0, q[3], 1'b0, q[1:0]});
		apb(1'b1, `REG_STATUS, 32'h0000_0043);
		load(`CMD_RELOAD);
		chk("reloadHot", 32'h0000_0000, {31'h0, q[6]});
		store(8'h7F, 1'b1);
		chk("storeReq", 32'h0000_0000, nStore);
		store(8'h7C, 1'b0);
		chk("lock", 32'h0000_0000, {31'h0, q[3]});
		chk("storeReq", 32'h0000_0001, nStore);
		$display("temperature test done");
		complete_run();
	end
endmodule
